/* File: rtl/lwt_pkg.sv */
package lwt_pkg;

  // Register byte addresses on the APB window.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PINSEL = 8'h04;
  localparam logic [7:0] ADDR_WKEN = 8'h08;
  localparam logic [7:0] ADDR_CAUSE = 8'h0C;
  localparam logic [7:0] ADDR_OPT = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PINSEL_RST = 32'h0000_0000;
  localparam logic [31:0] WKEN_RST = 32'h0000_0000;
  localparam logic [31:0] CAUSE_RST = 32'h0000_0000;
  localparam logic OPT_DIV_RST = 1'b1;

  // Writable bits; everything else is reserved and reads zero.
  localparam logic [31:0] CTRL_WMASK = 32'hFFFF_FBFF;
  localparam logic [31:0] WKEN_WMASK = 32'hFFFF_0701;
  localparam logic [31:0] CAUSE_MASK = 32'h07FF_0000;

  // Wake cause bit positions, and the divide bit of the option register.
  localparam int CAUSE_RT = 26;
  localparam int CAUSE_PER = 25;
  localparam int CAUSE_ROV = 24;
  localparam int CAUSE_PIN_MSB = 23;
  localparam int OPT_DIV_BIT = 0;

  localparam logic [1:0] CLK_RC32K = 2'h0;
  localparam logic [1:0] CLK_XOSC32K = 2'h1;
  localparam logic [1:0] CLK_RC16M = 2'h2;

  localparam logic [1:0] DET_OFF = 2'h0;
  localparam logic [1:0] DET_RISE = 2'h1;
  localparam logic [1:0] DET_FALL = 2'h2;
  localparam logic [1:0] DET_ANY = 2'h3;

  // Terminal counts of the prescalers and of the millisecond phase.
  localparam logic [8:0] LAST_32K = 9'h01F;
  localparam logic [8:0] LAST_RC16 = 9'h1FF;
  localparam logic [9:0] MS_LAST = 10'h3E7;

  typedef struct packed {
    logic counter_enable;
    logic realtime_irq_enable;
    logic realtime_match_flag;
    logic rollover_flag;
    logic [11:0] realtime_compare_value;
    logic periodic_enable;
    logic periodic_irq_enable;
    logic periodic_match_flag;
    logic [1:0] lowpower_clock_select;
    logic reserved;
    logic [9:0] periodic_compare_value;
  } lwt_ctrl_t;

  typedef struct packed {
    logic [7:0][1:0] pin_slot_detect;
    logic [4:0] zero_hi;
    logic rollover_wake_enable;
    logic realtime_wake_enable;
    logic periodic_wake_enable;
    logic [6:0] zero_lo;
    logic wake_clock_choice;
  } lwt_wken_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } lwt_apb_req_t;

endpackage : lwt_pkg

/* File: rtl/lwt_tick_gen.sv */
`timescale 1ns/1ps
module lwt_tick_gen (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic rc16_clk_i,
  input wire logic rc32k_clk_i,
  input wire logic xosc32k_clk_i,
  input wire logic [1:0] clock_select_i,
  input wire logic rc16_divide_i,
  output logic lp_edge_o,
  output logic ms_tick_o
);
  import lwt_pkg::*;

  // The 16 MHz source is close to half of mclk, so edges may alias away.
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] rise;
  logic sel_edge;
  logic [8:0] pre;
  logic [8:0] last;
  logic bypass;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= {rc16_clk_i, xosc32k_clk_i, rc32k_clk_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & ~sync3;

  always_comb begin
    sel_edge = 1'b0;
    last = LAST_32K;
    bypass = 1'b0;
    unique case (clock_select_i)
      CLK_RC32K: sel_edge = rise[0];
      CLK_XOSC32K: sel_edge = rise[1];
      CLK_RC16M: begin
        sel_edge = rise[2];
        last = LAST_RC16;
        bypass = ~rc16_divide_i;
      end
      default: sel_edge = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pre <= 9'h000;
      lp_edge_o <= 1'b0;
      ms_tick_o <= 1'b0;
    end else begin
      lp_edge_o <= sel_edge;
      ms_tick_o <= sel_edge & (bypass | (pre >= last));
      if (sel_edge) begin
        pre <= (pre >= last) ? 9'h000 : pre + 9'h001;
      end
    end
  end

endmodule : lwt_tick_gen

/* File: rtl/lwt_pin_slot.sv */
`timescale 1ns/1ps
module lwt_pin_slot #(
  parameter int CAND = 8
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [CAND-1:0] cand_i,
  input wire logic [3:0] select_i,
  input wire logic [1:0] detect_i,
  input wire logic sample_i,
  output logic event_o
);
  import lwt_pkg::*;

  logic [CAND-1:0] sync1;
  logic [CAND-1:0] sync2;
  logic cur;
  logic prev;
  logic hit;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= cand_i;
      sync2 <= sync1;
    end
  end

  // Codes with the top bit set choose no pin.
  assign cur = select_i[3] ? 1'b0 : sync2[select_i[2:0]];

  always_comb begin
    hit = 1'b0;
    unique case (detect_i)
      DET_OFF: hit = 1'b0;
      DET_RISE: hit = cur & ~prev;
      DET_FALL: hit = ~cur & prev;
      DET_ANY: hit = cur ^ prev;
    endcase
  end

  // The pin is looked at only on the low-power clock edge.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      prev <= 1'b0;
      event_o <= 1'b0;
    end else begin
      event_o <= sample_i & hit & ~select_i[3];
      if (sample_i) begin
        prev <= cur;
      end
    end
  end

endmodule : lwt_pin_slot

/* File: rtl/lwt_top.sv */
// What this block does
// - One shared 32-bit free-running counter is the time base of both timers.
// - Clock select code 10 picks 16 MHz RC, 00 32 kHz RC, 01 crystal.
// - With a 32 kHz source a fixed prescaler makes each count one millisecond.
// - The 16 MHz RC counts at full rate or through a divide-by-512 stage.
// - Real-time compare is 12 bits in seconds, one second to one hour.
// - Periodic compare is 10 bits in milliseconds, one millisecond to one second.
// - Compare values may be rewritten while running and take effect at once.
// - Match, rollover and periodic events set flags; interrupt enables gate requests.
// - Control bits: enable 0, irq enable 1, match 2, rollover 3, compare 4-15.
// - Periodic enable 16, irq enable 17, flag 18, clock select 19-20, compare low.
// - A timer event wakes only when its counter and its wake enable are set.
// - Pin edges are sampled on the selected low-power clock edge.
// - On wakeup the 16 MHz RC is requested as system clock.
// - Eight pin slots, each choosing one of its own eight pins from 64.
// - Four-bit select per slot, slot 0 at bits 28-31; top bit set is reserved.
// - All wake sources are off after reset; selection alone never wakes.
// - Enable bits 21, 22, 23 enable rollover, real-time and periodic wakeups.
// - Two-bit detect per slot: 00 off, 01 rising, 10 falling, 11 any edge.
// - Cause flags: bits 5-7 timer sources, bits 8-15 the eight pin slots.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module lwt_top #(
  parameter int SLOTS = 8
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire lwt_pkg::lwt_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rc16_clk_i,
  input wire logic rc32k_clk_i,
  input wire logic xosc32k_clk_i,
  input wire logic [8*SLOTS-1:0] pins_i,
  output logic realtime_irq_o,
  output logic periodic_irq_o,
  output logic wakeup_o,
  output logic rc16_request_o
);
  import lwt_pkg::*;

  lwt_ctrl_t ctrl;
  lwt_ctrl_t next_ctrl;
  lwt_wken_t wken;
  logic [31:0] pinsel;
  logic [31:0] cause;
  logic [31:0] next_cause;
  logic [31:0] cnt;
  logic opt_div;
  logic [9:0] ms_phase;
  logic [11:0] sec_count;
  logic [11:0] next_sec;
  logic [9:0] per_count;
  logic [9:0] next_per;
  logic lp_edge;
  logic ms_tick;
  logic [SLOTS-1:0] pin_evt;
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] wmask;
  logic [31:0] clr;
  logic [31:0] rdata;
  logic step;
  logic sec_tick;
  logic rov_evt;
  logic rt_evt;
  logic per_evt;

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wm,
                                        input logic [31:0] d);
    return (old & ~wm) | (d & wm);
  endfunction : merge

  lwt_tick_gen u_tick (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .rc16_clk_i(rc16_clk_i),
    .rc32k_clk_i(rc32k_clk_i),
    .xosc32k_clk_i(xosc32k_clk_i),
    .clock_select_i(ctrl.lowpower_clock_select),
    .rc16_divide_i(opt_div),
    .lp_edge_o(lp_edge),
    .ms_tick_o(ms_tick)
  );

  for (genvar k = 0; k < SLOTS; k++) begin : g_slot
    lwt_pin_slot #(
      .CAND(8)
    ) u_slot (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .cand_i(pins_i[8*k +: 8]),
      .select_i(pinsel[4*k +: 4]),
      .detect_i(wken.pin_slot_detect[k]),
      .sample_i(lp_edge),
      .event_o(pin_evt[k])
    );
  end

  // APB access decode; a write lands on the edge where pready is seen high.
  assign acc = apb_i.psel & apb_i.penable;
  assign wr = acc & apb_i.pwrite & pready_o & mapped;
  assign wmask = lane_mask(apb_i.pstrb);
  assign clr = apb_i.pwdata & wmask;

  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    unique case (apb_i.paddr)
      ADDR_CTRL: rdata = ctrl;
      ADDR_PINSEL: rdata = pinsel;
      ADDR_WKEN: rdata = wken;
      ADDR_CAUSE: rdata = cause;
      ADDR_OPT: rdata[OPT_DIV_BIT] = opt_div;
      ADDR_COUNT: rdata = cnt;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
      if (acc & ~pready_o & ~apb_i.pwrite) begin
        prdata_o <= rdata;
      end
    end
  end

  // Timer events, all derived from the one counter tick.
  assign step = ms_tick & (ctrl.counter_enable | ctrl.periodic_enable);
  assign rov_evt = step & ctrl.counter_enable & (cnt == 32'hFFFF_FFFF);
  assign sec_tick = step & ctrl.counter_enable & (ms_phase == MS_LAST);
  assign next_sec = sec_count + 12'h001;
  assign next_per = per_count + 10'h001;
  // Comparing with >= lets a value lowered below the count fire next tick.
  assign rt_evt = sec_tick & (next_sec >= ctrl.realtime_compare_value);
  assign per_evt = step & ctrl.periodic_enable
                   & (next_per >= ctrl.periodic_compare_value);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cnt <= 32'h0000_0000;
    end else if (step) begin
      cnt <= cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ms_phase <= 10'h000;
      sec_count <= 12'h000;
    end else if (!ctrl.counter_enable) begin
      ms_phase <= 10'h000;
      sec_count <= 12'h000;
    end else if (step) begin
      ms_phase <= (ms_phase == MS_LAST) ? 10'h000 : ms_phase + 10'h001;
      if (sec_tick) begin
        sec_count <= rt_evt ? 12'h000 : next_sec;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      per_count <= 10'h000;
    end else if (!ctrl.periodic_enable) begin
      per_count <= 10'h000;
    end else if (step) begin
      per_count <= per_evt ? 10'h000 : next_per;
    end
  end

  // Control register: plain fields merge, flags are write-one-to-clear.
  always_comb begin
    next_ctrl = ctrl;
    if (wr && apb_i.paddr == ADDR_CTRL) begin
      next_ctrl = lwt_ctrl_t'(merge(ctrl, wmask & CTRL_WMASK, apb_i.pwdata));
      next_ctrl.realtime_match_flag = ctrl.realtime_match_flag & ~clr[29];
      next_ctrl.rollover_flag = ctrl.rollover_flag & ~clr[28];
      next_ctrl.periodic_match_flag = ctrl.periodic_match_flag & ~clr[13];
    end
    // A new event wins over a clear in the same cycle.
    if (rt_evt) begin
      next_ctrl.realtime_match_flag = 1'b1;
    end
    if (rov_evt) begin
      next_ctrl.rollover_flag = 1'b1;
    end
    if (per_evt) begin
      next_ctrl.periodic_match_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl <= lwt_ctrl_t'(CTRL_RST);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pinsel <= PINSEL_RST;
      opt_div <= OPT_DIV_RST;
    end else if (wr) begin
      if (apb_i.paddr == ADDR_PINSEL) begin
        pinsel <= merge(pinsel, wmask, apb_i.pwdata);
      end
      if (apb_i.paddr == ADDR_OPT && apb_i.pstrb[0]) begin
        opt_div <= apb_i.pwdata[OPT_DIV_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wken <= lwt_wken_t'(WKEN_RST);
    end else if (wr && apb_i.paddr == ADDR_WKEN) begin
      wken <= lwt_wken_t'(merge(wken, wmask & WKEN_WMASK, apb_i.pwdata));
    end
  end

  // Wake causes: timer events count only with their wake enable set.
  always_comb begin
    next_cause = cause;
    if (wr && apb_i.paddr == ADDR_CAUSE) begin
      next_cause = cause & ~(clr & CAUSE_MASK);
    end
    if (rt_evt && wken.realtime_wake_enable) begin
      next_cause[CAUSE_RT] = 1'b1;
    end
    if (per_evt && wken.periodic_wake_enable) begin
      next_cause[CAUSE_PER] = 1'b1;
    end
    if (rov_evt && wken.rollover_wake_enable) begin
      next_cause[CAUSE_ROV] = 1'b1;
    end
    for (int k = 0; k < SLOTS; k++) begin
      if (pin_evt[k]) begin
        next_cause[CAUSE_PIN_MSB - k] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cause <= CAUSE_RST;
    end else begin
      cause <= next_cause;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      realtime_irq_o <= 1'b0;
      periodic_irq_o <= 1'b0;
      wakeup_o <= 1'b0;
      rc16_request_o <= 1'b0;
    end else begin
      realtime_irq_o <= ctrl.realtime_irq_enable
                        & (ctrl.realtime_match_flag | ctrl.rollover_flag);
      periodic_irq_o <= ctrl.periodic_irq_enable & ctrl.periodic_match_flag;
      wakeup_o <= |cause;
      // The 16 MHz RC stays requested while any wake cause is pending.
      rc16_request_o <= |cause;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_cnt_step;
    step |=> cnt == $past(cnt) + 32'h0000_0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

  property p_cnt_hold;
    !step |=> $stable(cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without tick");

  property p_rollover;
    ms_tick && ctrl.counter_enable && cnt == 32'hFFFF_FFFF |=> ctrl.rollover_flag && cnt == 0;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover flag missed");

  property p_per_match;
    // The output is registered, so it follows the enable of the cycle before.
    per_evt |=> ctrl.periodic_match_flag ##1
      (periodic_irq_o == $past(ctrl.periodic_irq_enable));
  endproperty
  a_per_match: assert property (p_per_match) else $error("periodic flag or irq wrong");

  property p_rt_wake_gate;
    $rose(cause[CAUSE_RT]) |-> $past(wken.realtime_wake_enable) && $past(ctrl.counter_enable);
  endproperty
  a_rt_wake_gate: assert property (p_rt_wake_gate) else $error("ungated timer wake");

  property p_flag_sticky;
    ctrl.realtime_match_flag && !wr |=> ctrl.realtime_match_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

  property p_wake_out;
    (|cause) ##1 (|cause) |-> wakeup_o && rc16_request_o;
  endproperty
  a_wake_out: assert property (p_wake_out) else $error("wakeup not driven");

  property p_apb_ready;
    acc && !pready_o |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready not one cycle");

  // A lowered compare value may leave the count above it until the next tick.
  property p_per_bound;
    ctrl.periodic_enable && step
      |=> per_count == 10'h000 || per_count < $past(ctrl.periodic_compare_value);
  endproperty
  a_per_bound: assert property (p_per_bound) else $error("periodic count overran");

  property p_pin_cause;
    (|pin_evt) |=> (|cause[CAUSE_PIN_MSB -: SLOTS]);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin event not recorded");

endmodule : lwt_top

/* File: bench/lwt_lp_src.sv */
`timescale 1ns/1ps
module lwt_lp_src #(
  parameter int RC16_HALF = 83,
  parameter int RC32_HALF = 121,
  parameter int XO32_HALF = 137
) (
  input wire logic [63:0] level_i,
  output logic rc16_o,
  output logic rc32k_o,
  output logic crystal_oscillator_o,
  output logic [63:0] pins_o
);
  // The 32 kHz rates are scaled up so a run stays short, with phases unrelated to the system clock.
  // The sources run free, as oscillators do, so a pin edge always has a clock to latch it.
  initial begin
    rc16_o = 1'b0;
    rc32k_o = 1'b0;
    crystal_oscillator_o = 1'b0;
  end
  always #(RC16_HALF) rc16_o = ~rc16_o;
  always #(RC32_HALF) rc32k_o = ~rc32k_o;
  always #(XO32_HALF) crystal_oscillator_o = ~crystal_oscillator_o;
  assign pins_o = level_i;
endmodule : lwt_lp_src

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import lwt_pkg::*;
  logic mclk = 1'b0;
  logic rstn;
  lwt_apb_req_t apb;
  logic [31:0] prdata;
  logic pready, pslverr, rt_irq, per_irq, wake, rc16_req, rc16, rc32k, crystal_oscillator;
  logic [63:0] lvl, pins;
  int failures = 0;
  int checks_done = 0;
  int unsigned regm[int];
  int sel_t[5] = '{0, 1, 2, 2, 3};
  int dv_t[5] = '{1, 1, 1, 0, 1};
  int n_t[5] = '{2, 2, 1, 6, 2};
  longint p_t[5] = '{7744, 8768, 84992, 166, 0};

  always #20 mclk = ~mclk;

  lwt_lp_src i_src (.level_i(lvl), .rc16_o(rc16), .rc32k_o(rc32k), .crystal_oscillator_o(crystal_oscillator),
    .pins_o(pins));
  lwt_top i_dut (.mclk_i(mclk), .rstn_i(rstn), .apb_i(apb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rc16_clk_i(rc16), .rc32k_clk_i(rc32k),
    .xosc32k_clk_i(crystal_oscillator), .pins_i(pins), .realtime_irq_o(rt_irq),
    .periodic_irq_o(per_irq), .wakeup_o(wake), .rc16_request_o(rc16_req));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic apb_x(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= w;
    apb.paddr <= a;
    apb.pwdata <= d;
    @(posedge mclk);
    apb.penable <= 1'b1;
    // Values read here are those the rising edge samples, before it updates them.
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) chk(pready, 1'b1);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_x

  // The model keeps written values; flags are never stored since events add them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb_x(1'b1, a, d, q, e);
    case (a)
      ADDR_CTRL: regm[a] = d & CTRL_WMASK & ~32'h3000_2000;
      ADDR_WKEN: regm[a] = d & WKEN_WMASK;
      ADDR_PINSEL: regm[a] = d;
      ADDR_OPT: regm[a] = d & 32'h0000_0001;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ev);
    logic [31:0] q;
    logic e;
    apb_x(1'b0, a, 32'h0000_0000, q, e);
    chk(q, (regm.exists(a) ? regm[a] : 32'h0000_0000) | ev);
    chk(e, !regm.exists(a));
  endtask : rd

  task automatic wait_irq(input int which, input int lim, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((which ? rt_irq : per_irq) !== 1'b1 && n < lim);
  endtask : wait_irq

  task automatic cleanup;
    // A second write clears a flag that an event set in the cycle of the first.
    wr(ADDR_CTRL, 32'h3000_2000);
    wr(ADDR_CTRL, 32'h3000_2000);
    wr(ADDR_CAUSE, 32'hFFFF_FFFF);
    rd(ADDR_CAUSE, 32'h0000_0000);
    chk(per_irq | rt_irq | wake, 1'b0);
  endtask : cleanup

  task automatic t_regs;
    logic [31:0] r;
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_PINSEL, 32'h0000_0000);
    rd(ADDR_WKEN, 32'h0000_0000);
    rd(ADDR_CAUSE, 32'h0000_0000);
    rd(ADDR_OPT, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    wr(ADDR_COUNT, 32'hFFFF_FFFF);
    rd(ADDR_COUNT, 32'h0000_0000);
    r = $urandom();
    wr(ADDR_PINSEL, r);
    rd(ADDR_PINSEL, 32'h0000_0000);
    wr(ADDR_WKEN, $urandom());
    rd(ADDR_WKEN, 32'h0000_0000);
    wr(ADDR_CTRL, $urandom() & 32'h4FFF_5FFF);
    rd(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_WKEN, 32'h0000_0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_per;
    lwt_ctrl_t c;
    int n, lim;
    longint t0, dt;
    logic wk;
    for (int i = 0; i < 5; i++) begin
      c = '0;
      c.lowpower_clock_select = sel_t[i][1:0];
      c.periodic_compare_value = n_t[i][9:0];
      c.periodic_enable = 1'b1;
      c.periodic_irq_enable = 1'b1;
      wk = i[0] && p_t[i] != 0;
      lim = (p_t[i] == 0) ? 3000 : int'(n_t[i] * p_t[i] / 40) + 50;
      wr(ADDR_OPT, dv_t[i]);
      wr(ADDR_WKEN, i[0] ? 32'h0000_0100 : 32'h0000_0000);
      wr(ADDR_CTRL, c);
      t0 = $time;
      wait_irq(0, lim, n);
      dt = $time - t0;
      if (p_t[i] == 0) chk(n, lim);
      else chk(dt >= (n_t[i] - 1) * p_t[i] && dt <= n_t[i] * p_t[i] + 400, 1'b1);
      repeat (3) @(posedge mclk);
      rd(ADDR_CTRL, p_t[i] != 0 ? 32'h0000_2000 : 32'h0000_0000);
      rd(ADDR_CAUSE, wk ? 32'h0200_0000 : 32'h0000_0000);
      chk(wake, wk);
      chk(rc16_req, wk);
      cleanup();
    end
    $display("test periodic done");
  endtask : t_per

  task automatic t_upd;
    lwt_ctrl_t c;
    int n;
    c = '0;
    c.lowpower_clock_select = 2'h2;
    c.periodic_compare_value = 10'h3FF;
    c.periodic_enable = 1'b1;
    c.periodic_irq_enable = 1'b1;
    wr(ADDR_OPT, 32'h0000_0000);
    wr(ADDR_CTRL, c);
    repeat (50) @(posedge mclk);
    c.periodic_compare_value = 10'h004;
    wr(ADDR_CTRL, c);
    wait_irq(0, 40, n);
    chk(n < 40, 1'b1);
    cleanup();
    $display("test compare update done");
  endtask : t_upd

  task automatic t_rt;
    lwt_ctrl_t c;
    int n;
    longint t0, dt;
    c = '0;
    c.counter_enable = 1'b1;
    c.realtime_irq_enable = 1'b1;
    c.realtime_compare_value = 12'h002;
    c.lowpower_clock_select = 2'h2;
    wr(ADDR_WKEN, 32'h0000_0200);
    wr(ADDR_CTRL, c);
    t0 = $time;
    wait_irq(1, 8400, n);
    dt = $time - t0;
    chk(dt >= 1999 * 166 && dt <= 2000 * 166 + 400, 1'b1);
    repeat (3) @(posedge mclk);
    rd(ADDR_CTRL, 32'h2000_0000);
    rd(ADDR_CAUSE, 32'h0400_0000);
    chk(wake, 1'b1);
    cleanup();
    $display("test realtime done");
  endtask : t_rt

  task automatic t_pins;
    int k, j;
    logic [63:0] v;
    logic [1:0] det;
    k = $urandom_range(7);
    j = $urandom_range(7);
    v = {$urandom(), $urandom()};
    v[8 * k + j] = 1'b0;
    lvl <= v;
    wr(ADDR_WKEN, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_1000);
    for (int code = 0; code < 5; code++) begin
      det = (code == 4) ? 2'h3 : code[1:0];
      wr(ADDR_PINSEL, {28'h0, code[2], j[2:0]} << (4 * k));
      wr(ADDR_WKEN, {30'h0, det} << (2 * k + 16));
      v[8 * k + j] = 1'b1;
      lvl <= v;
      repeat (20) @(posedge mclk);
      rd(ADDR_CAUSE, (code == 1 || code == 3) ? 32'h1 << (23 - k) : 32'h0);
      wr(ADDR_CAUSE, 32'hFFFF_FFFF);
      v[8 * k + j] = 1'b0;
      lvl <= v;
      repeat (20) @(posedge mclk);
      rd(ADDR_CAUSE, (code == 2 || code == 3) ? 32'h1 << (23 - k) : 32'h0);
      wr(ADDR_CAUSE, 32'hFFFF_FFFF);
    end
    $display("test pins done");
  endtask : t_pins

  initial begin
    apb = '0;
    apb.pstrb = 4'hF;
    lvl = '0;
    rstn = 1'b0;
    regm[ADDR_CTRL] = CTRL_RST;
    regm[ADDR_PINSEL] = PINSEL_RST;
    regm[ADDR_WKEN] = WKEN_RST;
    regm[ADDR_CAUSE] = CAUSE_RST;
    regm[ADDR_OPT] = {31'h0, OPT_DIV_RST};
    regm[ADDR_COUNT] = 32'h0000_0000;
    void'($urandom(8));
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_per();
    t_upd();
    t_rt();
    t_pins();
    report_and_stop();
  end

  // The tests need about 15000 cycles; four times that means a hang.
  initial begin
    #(40 * 60000);
    failures++;
    report_and_stop();
  end
endmodule : tb_top
